// ---- dv/acf_ctrl_test.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module acf_ctrl_test;
    import acf_pkg::*;
    localparam logic [23:0] PRI_F = 24'h3a5c71;
    localparam logic [15:0] AUX_F = 16'hb24e;
    logic sys_clk, nrst, mod_tick, sfr_wr, pri_active, aux_active, cal_done, cal_pri, rd_pend;
    logic clk_en;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, filter_decimation, lfsr, v;
    logic [2:0] cal_mode_field;
    logic [23:0] cal_gain_value;
    logic result_tick, result_valid, calibrating, burnout_enable, aux_current_correct, pri_current_correct;
    logic src1_to_pin_a, src1_to_pin_b, src2_to_pin_a, src2_to_pin_b;
    logic [7:0] rd_q[$];
    int tick_q[$];
    int error_cnt, check_count, ticks;

    acf_ctrl #(.PRI_GAIN_FACTORY(PRI_F), .AUX_GAIN_FACTORY(AUX_F)) u_acf_ctrl (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .mod_tick(mod_tick),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
        .cal_mode_field(cal_mode_field), .pri_active(pri_active), .aux_active(aux_active),
        .cal_done(cal_done), .cal_pri(cal_pri), .cal_gain_value(cal_gain_value),
        .filter_decimation(filter_decimation), .result_tick(result_tick), .result_valid(result_valid),
        .calibrating(calibrating), .burnout_enable(burnout_enable), .aux_current_correct(aux_current_correct),
        .pri_current_correct(pri_current_correct), .src1_to_pin_a(src1_to_pin_a),
        .src1_to_pin_b(src1_to_pin_b), .src2_to_pin_a(src2_to_pin_a), .src2_to_pin_b(src2_to_pin_b)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        report({8'h00, got}, {8'h00, exp});
    endtask

    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        report({8'h00, got}, {8'h00, exp});
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        sfr_addr = a;
        rd_q.push_back(e);
        rd_pend = 1'b1;
        @(negedge sys_clk);
        rd_pend = 1'b0;
    endtask

    task automatic rd_gains(input logic [23:0] p, input logic [15:0] x);
        for (int i = 0; i < 5; i++)
            rd(GN_PRI_L_OFS + 8'(i), i < 3 ? p[8*i +: 8] : x[8*(i-3) +: 8]);
    endtask

    task automatic cal(input logic [2:0] m, input logic p, input logic [23:0] g);
        @(negedge sys_clk);
        cal_mode_field = m;
        cal_pri = p;
        repeat (2) @(negedge sys_clk);
        cmp_out({7'h00, calibrating}, 8'h01);
        cmp_out(filter_decimation, DEC_CAL);
        cal_gain_value = g;
        cal_done = 1'b1;
        @(negedge sys_clk);
        cal_done = 1'b0;
        cal_mode_field = MODE_IDLE;
        repeat (2) @(negedge sys_clk);
        cmp_out(filter_decimation, DEC_MIN);
    endtask

    // Read data lands one cycle after the address
    always @(posedge sys_clk)
    begin
        #1;
        if (rd_pend === 1'b1 && rd_q.size() > 0)
            cmp_rd(sfr_rdata, rd_q.pop_front());
        if (result_tick === 1'b1 && tick_q.size() > 0)
            report(16'(ticks), 16'(tick_q.pop_front()));
    end

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        #100000;
        error_cnt++;
        final_report();
    end

    initial
    begin
        {nrst, mod_tick, sfr_wr, pri_active, aux_active, cal_done, cal_pri, rd_pend} = '0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        clk_en = 1'b1;
        cal_mode_field = MODE_IDLE;
        cal_gain_value = 24'h000000;
        error_cnt = 0;
        check_count = 0;
        ticks = 0;
        lfsr = 8'h15;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp_out(filter_decimation, DEC_RESET);
        rd(DEC_OFS, DEC_RESET);
        rd(CURRENT_SOURCE_CONTROL_OFS, CURRENT_SOURCE_CONTROL_RESET);
        rd_gains(PRI_F, AUX_F);
        repeat (12)
        begin
            lfsr = lfsr_next(lfsr);
            v = lfsr;
            wr(CURRENT_SOURCE_CONTROL_OFS, v);
            @(negedge sys_clk);
            cmp_out({1'b0, burnout_enable, aux_current_correct, pri_current_correct, src2_to_pin_a, src2_to_pin_b,
                src1_to_pin_a, src1_to_pin_b}, {1'b0, v[6:4], v[1] & v[3], v[1] & ~v[3], v[0] & ~v[2],
                v[0] & v[2]});
            rd(CURRENT_SOURCE_CONTROL_OFS, v & 8'h7f);
        end
        // Frozen clock enable must drop the write
        clk_en = 1'b0;
        wr(CURRENT_SOURCE_CONTROL_OFS, 8'h5a);
        @(negedge sys_clk);
        clk_en = 1'b1;
        rd(CURRENT_SOURCE_CONTROL_OFS, v & 8'h7f);
        for (int i = 0; i < 5; i++)
            wr(GN_PRI_L_OFS + 8'(i), 8'h1d + 8'(17 * i));
        for (int m = 1; m < 8; m++)
        begin
            cal_mode_field = 3'(m);
            wr(GN_PRI_L_OFS + 8'(m % 5), 8'hc3);
        end
        cal_mode_field = MODE_IDLE;
        rd_gains(24'h3f2e1d, 16'h6150);
        pri_active = 1'b1;
        wr(DEC_OFS, 8'h80);
        pri_active = 1'b0;
        aux_active = 1'b1;
        wr(DEC_OFS, 8'h81);
        aux_active = 1'b0;
        rd(DEC_OFS, DEC_RESET);
        wr(DEC_OFS, DEC_MIN);
        rd(DEC_OFS, DEC_MIN);
        cal(MODE_INT_FS, 1'b1, 24'h6b7c8d);
        cal(MODE_SYS_FS, 1'b0, 24'h9eaf10);
        rd_gains(24'h6b7c8d, 16'h9eaf);
        rd(DEC_OFS, DEC_MIN);
        // Chopped start: first result after two periods
        tick_q.push_back(CHOP_PERIODS * RATE_DIV * 13);
        tick_q.push_back((CHOP_PERIODS + 1) * RATE_DIV * 13);
        @(negedge sys_clk);
        pri_active = 1'b1;
        repeat (1000)
        begin
            @(negedge sys_clk);
            mod_tick = 1'b1;
            ticks++;
            @(negedge sys_clk);
            mod_tick = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        report(16'(tick_q.size()), 16'h0000);
        cmp_out({7'h00, result_valid}, 8'h01);
        final_report();
    end
endmodule

// ---- hdl/acf_ctrl.sv ----
// Gain coefficients, decimation factor and current source control
`timescale 1ns/100ps
// Notes on behaviour
// - 24-bit primary gain in three bytes, factory default
// - 16-bit aux gain in two bytes, factory default
// - Full-scale calibration overwrites the calibrated gain
// - Coefficient writes only when mode field zero
// - Decimation writes blocked while converter active
// - Update period is 24 times decimation modulator ticks
// - Decimation resets to 0x45
// - First result after two conversion periods
// - Calibration runs at 0xff, register keeps value
// - Bit 6 drives both burnout currents
// - Bit 5 enables aux current correction
// - Bit 4 enables primary current correction
// - Bit 3 routes source two to pin a
// - Bit 2 routes source one to pin b
// - Bit 1 enables source two
// - Bit 0 enables source one
// - Control register resets zero, bit 7 reserved
module acf_ctrl #(
    parameter logic [23:0] PRI_GAIN_FACTORY = 24'h555555,
    parameter logic [15:0] AUX_GAIN_FACTORY = 16'h5555
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic mod_tick,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    output logic [7:0] sfr_rdata,
    input wire logic [2:0] cal_mode_field,
    input wire logic pri_active,
    input wire logic aux_active,
    input wire logic cal_done,
    input wire logic cal_pri,
    input wire logic [23:0] cal_gain_value,
    output logic [7:0] filter_decimation,
    output logic result_tick,
    output logic result_valid,
    output logic calibrating,
    output logic burnout_enable,
    output logic aux_current_correct,
    output logic pri_current_correct,
    output logic src1_to_pin_a,
    output logic src1_to_pin_b,
    output logic src2_to_pin_a,
    output logic src2_to_pin_b
);
    import acf_pkg::*;

    logic [7:0] current_source_control_reg, current_source_control_next;
    logic [7:0] dec_reg, dec_next;
    logic [23:0] pri_gain_reg, pri_gain_next;
    logic [15:0] aux_gain_reg, aux_gain_next;
    logic [7:0] rdata_reg, rdata_next;
    logic gain_loaded_reg, gain_loaded_next;
    acf_state_e state_reg, state_next;
    logic [12:0] tick_cnt_reg, tick_cnt_next;
    logic [1:0] period_cnt_reg, period_cnt_next;
    logic [7:0] fdec_reg, fdec_next;
    logic rtick_reg, rtick_next;
    logic rvalid_reg, rvalid_next;
    logic cal_reg, cal_next;
    logic [7:0] cs_reg, cs_next;

    wire logic conv_active = pri_active | aux_active;
    wire logic is_fs_cal = (cal_mode_field == MODE_INT_FS) || (cal_mode_field == MODE_SYS_FS);

    function automatic logic [12:0] period_ticks(input logic [7:0] dec);
        period_ticks = 13'(RATE_DIV) * {5'h0, dec};
    endfunction

    // Register file
    always_comb
    begin
        current_source_control_next = current_source_control_reg;
        dec_next = dec_reg;
        pri_gain_next = pri_gain_reg;
        aux_gain_next = aux_gain_reg;
        gain_loaded_next = 1'b1;
        if (!gain_loaded_reg)
        begin
            pri_gain_next = PRI_GAIN_FACTORY;
            aux_gain_next = AUX_GAIN_FACTORY;
        end
        else if (sfr_wr)
        begin
            case (sfr_addr)
                CURRENT_SOURCE_CONTROL_OFS: current_source_control_next = {1'b0, sfr_wdata[6:0]};
                DEC_OFS: if (!conv_active) dec_next = sfr_wdata;
                GN_PRI_L_OFS: if (cal_mode_field == MODE_IDLE) pri_gain_next[7:0] = sfr_wdata;
                GN_PRI_M_OFS: if (cal_mode_field == MODE_IDLE) pri_gain_next[15:8] = sfr_wdata;
                GN_PRI_H_OFS: if (cal_mode_field == MODE_IDLE) pri_gain_next[23:16] = sfr_wdata;
                GN_AUX_L_OFS: if (cal_mode_field == MODE_IDLE) aux_gain_next[7:0] = sfr_wdata;
                GN_AUX_H_OFS: if (cal_mode_field == MODE_IDLE) aux_gain_next[15:8] = sfr_wdata;
                default: ;
            endcase
        end
        if (gain_loaded_reg && cal_done && is_fs_cal)
        begin
            if (cal_pri)
                pri_gain_next = cal_gain_value;
            else
                aux_gain_next = cal_gain_value[23:8];
        end
        case (sfr_addr)
            CURRENT_SOURCE_CONTROL_OFS: rdata_next = current_source_control_reg;
            DEC_OFS: rdata_next = dec_reg;
            GN_PRI_L_OFS: rdata_next = pri_gain_reg[7:0];
            GN_PRI_M_OFS: rdata_next = pri_gain_reg[15:8];
            GN_PRI_H_OFS: rdata_next = pri_gain_reg[23:16];
            GN_AUX_L_OFS: rdata_next = aux_gain_reg[7:0];
            GN_AUX_H_OFS: rdata_next = aux_gain_reg[15:8];
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            current_source_control_reg <= CURRENT_SOURCE_CONTROL_RESET;
            dec_reg <= DEC_RESET;
            pri_gain_reg <= 24'h000000;
            aux_gain_reg <= 16'h0000;
            rdata_reg <= 8'h00;
            gain_loaded_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            current_source_control_reg <= current_source_control_next;
            dec_reg <= dec_next;
            pri_gain_reg <= pri_gain_next;
            aux_gain_reg <= aux_gain_next;
            rdata_reg <= rdata_next;
            gain_loaded_reg <= gain_loaded_next;
        end
    end

    // Conversion timing and current source decode
    always_comb
    begin
        state_next = state_reg;
        tick_cnt_next = tick_cnt_reg;
        period_cnt_next = period_cnt_reg;
        rtick_next = 1'b0;
        rvalid_next = rvalid_reg;
        fdec_next = fdec_reg;
        cal_next = 1'b0;
        case (state_reg)
            ACF_IDLE:
            begin
                tick_cnt_next = 13'h0000;
                period_cnt_next = 2'h0;
                rvalid_next = 1'b0;
                fdec_next = dec_reg;
                if (cal_mode_field != MODE_IDLE && !conv_active)
                    state_next = ACF_CAL;
                else if (conv_active)
                    state_next = ACF_CONV;
            end
            ACF_CONV:
            begin
                fdec_next = dec_reg;
                if (!conv_active)
                    state_next = ACF_IDLE;
                else if (mod_tick)
                begin
                    if (tick_cnt_reg >= period_ticks(dec_reg) - 13'h0001)
                    begin
                        tick_cnt_next = 13'h0000;
                        if (period_cnt_reg < 2'(CHOP_PERIODS - 1))
                            period_cnt_next = period_cnt_reg + 2'h1;
                        else
                        begin
                            rtick_next = 1'b1;
                            rvalid_next = 1'b1;
                        end
                    end
                    else
                        tick_cnt_next = tick_cnt_reg + 13'h0001;
                end
            end
            ACF_CAL:
            begin
                cal_next = 1'b1;
                fdec_next = DEC_CAL;
                if (cal_mode_field == MODE_IDLE || cal_done)
                    state_next = ACF_IDLE;
            end
            default: state_next = ACF_IDLE;
        endcase
        cs_next[0] = current_source_control_reg[SRC1_EN_BIT] & ~current_source_control_reg[SRC1_PIN_BIT];
        cs_next[1] = current_source_control_reg[SRC1_EN_BIT] & current_source_control_reg[SRC1_PIN_BIT];
        cs_next[2] = current_source_control_reg[SRC2_EN_BIT] & current_source_control_reg[SRC2_PIN_BIT];
        cs_next[3] = current_source_control_reg[SRC2_EN_BIT] & ~current_source_control_reg[SRC2_PIN_BIT];
        cs_next[4] = current_source_control_reg[PRI_IC_BIT];
        cs_next[5] = current_source_control_reg[AUX_IC_BIT];
        cs_next[6] = current_source_control_reg[BO_BIT];
        cs_next[7] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ACF_IDLE;
            tick_cnt_reg <= 13'h0000;
            period_cnt_reg <= 2'h0;
            rtick_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            fdec_reg <= DEC_RESET;
            cal_reg <= 1'b0;
            cs_reg <= 8'h00;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            tick_cnt_reg <= tick_cnt_next;
            period_cnt_reg <= period_cnt_next;
            rtick_reg <= rtick_next;
            rvalid_reg <= rvalid_next;
            fdec_reg <= fdec_next;
            cal_reg <= cal_next;
            cs_reg <= cs_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign filter_decimation = fdec_reg;
    assign result_tick = rtick_reg;
    assign result_valid = rvalid_reg;
    assign calibrating = cal_reg;
    assign src1_to_pin_a = cs_reg[0];
    assign src1_to_pin_b = cs_reg[1];
    assign src2_to_pin_a = cs_reg[2];
    assign src2_to_pin_b = cs_reg[3];
    assign pri_current_correct = cs_reg[4];
    assign aux_current_correct = cs_reg[5];
    assign burnout_enable = cs_reg[6];

    property dec_block_p;
        @(posedge sys_clk) disable iff (!nrst)
        (clk_en && gain_loaded_reg && sfr_wr && sfr_addr == DEC_OFS && conv_active) |=> $stable(dec_reg);
    endproperty
    dec_write_block_a: assert property (dec_block_p) else $error("Decimation written while active");

    gain_write_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && gain_loaded_reg && sfr_wr && sfr_addr == GN_PRI_L_OFS && cal_mode_field != MODE_IDLE
         && !cal_done) |=> $stable(pri_gain_reg)) else $error("Gain written in nonzero mode");

    cal_gain_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && gain_loaded_reg && cal_done && is_fs_cal && cal_pri) |=> pri_gain_reg == $past(cal_gain_value))
        else $error("Calibration gain not loaded");

    current_source_control_reserved_a: assert property (@(posedge sys_clk) disable iff (!nrst) current_source_control_reg[7] == 1'b0)
        else $error("Reserved bit set");

    sequence current_source_control_set_s;
        clk_en && current_source_control_reg[BO_BIT];
    endsequence
    burnout_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        current_source_control_set_s |=> burnout_enable) else $error("Burnout not following bit");

    cal_dec_max_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        calibrating |-> filter_decimation == DEC_CAL) else $error("Calibration not at max decimation");

    first_result_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(result_valid) |-> $past(period_cnt_reg) == 2'(CHOP_PERIODS - 1)) else $error("Early first result");

    src_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(src2_to_pin_a && src2_to_pin_b)) else $error("Source two on both pins");

    sequence aux_gain_wr_s;
        clk_en && gain_loaded_reg && sfr_wr && (sfr_addr == GN_AUX_L_OFS || sfr_addr == GN_AUX_H_OFS);
    endsequence
    aux_gain_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        aux_gain_wr_s ##0 (cal_mode_field != MODE_IDLE && !cal_done) |=> $stable(aux_gain_reg))
        else $error("Aux gain written in nonzero mode");

    current_source_control_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && gain_loaded_reg && sfr_wr && sfr_addr == CURRENT_SOURCE_CONTROL_OFS)
        |=> current_source_control_reg == {1'b0, $past(sfr_wdata[6:0])})
        else $error("Control register write lost");

    dec_write_take_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && gain_loaded_reg && sfr_wr && sfr_addr == DEC_OFS && !conv_active)
        |=> dec_reg == $past(sfr_wdata))
        else $error("Decimation write lost while idle");

    aux_ic_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && current_source_control_reg[AUX_IC_BIT]) |=> aux_current_correct) else $error("Aux correction not following bit");

    pri_ic_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && current_source_control_reg[PRI_IC_BIT]) |=> pri_current_correct) else $error("Primary correction not following");

    src1_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && current_source_control_reg[SRC1_EN_BIT] && !current_source_control_reg[SRC1_PIN_BIT]) |=> src1_to_pin_a)
        else $error("Source one not on pin a");

    result_valid_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        result_tick |-> result_valid) else $error("Result without valid flag");
endmodule

// ---- hdl/acf_pkg.sv ----
// Package with register offsets, reset values and timing constants for the converter control block
package acf_pkg;
    localparam logic [7:0] CURRENT_SOURCE_CONTROL_OFS = 8'hd5;
    localparam logic [7:0] GN_PRI_L_OFS = 8'he9;
    localparam logic [7:0] GN_PRI_M_OFS = 8'hea;
    localparam logic [7:0] GN_PRI_H_OFS = 8'heb;
    localparam logic [7:0] GN_AUX_L_OFS = 8'hec;
    localparam logic [7:0] GN_AUX_H_OFS = 8'hed;
    localparam logic [7:0] DEC_OFS = 8'hd4;
    localparam logic [7:0] CURRENT_SOURCE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DEC_RESET = 8'h45;
    localparam logic [7:0] DEC_MIN = 8'h0d;
    localparam logic [7:0] DEC_CAL = 8'hff;
    localparam int BO_BIT = 6;
    localparam int AUX_IC_BIT = 5;
    localparam int PRI_IC_BIT = 4;
    localparam int SRC2_PIN_BIT = 3;
    localparam int SRC1_PIN_BIT = 2;
    localparam int SRC2_EN_BIT = 1;
    localparam int SRC1_EN_BIT = 0;
    localparam int RATE_DIV = 24;
    localparam int CHOP_PERIODS = 2;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_INT_FS = 3'h5;
    localparam logic [2:0] MODE_SYS_FS = 3'h7;
    typedef enum logic [1:0] {ACF_IDLE, ACF_CONV, ACF_CAL} acf_state_e;
endpackage
